// file: common/tmr_pkg.sv
// Purpose: Shared constants of the 8-bit compare-match timer channel
// Assumes: Byte-wide register port with a 3-bit register index
// Notes: Offsets and control bit positions are local choices
package tmr_pkg;
   // Register indices
   localparam logic [2:0] OFF_CONTROL = 3'h0;
   localparam logic [2:0] OFF_STATUS = 3'h1;
   localparam logic [2:0] OFF_CONST_A = 3'h2;
   localparam logic [2:0] OFF_CONST_B = 3'h3;
   localparam logic [2:0] OFF_COUNTER = 3'h4;
   // timer_control fields
   localparam int CTL_MATCH_B_IE = 7;
   localparam int CTL_MATCH_A_IE = 6;
   localparam int CTL_ROLL_IE = 5;
   localparam int CTL_CLR_HI = 4;
   localparam int CTL_CLR_LO = 3;
   localparam int CTL_CKS_HI = 2;
   // timer_status_output fields; flag vector order is {b, a, rollover}
   localparam int ST_FLAG_HI = 7;
   localparam int ST_FLAG_LO = 5;
   localparam int ST_OS_B_HI = 3;
   localparam int ST_OS_B_LO = 2;
   localparam int ST_OS_A_HI = 1;
   localparam int ST_OS_A_LO = 0;
   localparam int FLAG_B = 2;
   localparam int FLAG_A = 1;
   localparam int FLAG_ROLL = 0;
   // Reset values
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] STATUS_RESET = 8'h10;
   localparam logic [7:0] CONST_RESET = 8'hFF;
   localparam logic [7:0] COUNTER_RESET = 8'h00;
   localparam logic [7:0] COUNT_MAX = 8'hFF;
   // Counter clear select codes
   localparam logic [1:0] CLR_NONE = 2'h0;
   localparam logic [1:0] CLR_MATCH_A = 2'h1;
   localparam logic [1:0] CLR_MATCH_B = 2'h2;
   localparam logic [1:0] CLR_EXT = 2'h3;
   // Output actions; numeric order equals precedence
   localparam logic [1:0] OUT_KEEP = 2'h0;
   localparam logic [1:0] OUT_ZERO = 2'h1;
   localparam logic [1:0] OUT_ONE = 2'h2;
   localparam logic [1:0] OUT_TOGGLE = 2'h3;
   // Clock select low bits; bit 2 picks the external input
   localparam logic [1:0] CKS_STOP = 2'h0;
   localparam logic [1:0] CKS_DIV8 = 2'h1;
   localparam logic [1:0] CKS_DIV64 = 2'h2;
   localparam logic [1:0] CKS_DIV1024 = 2'h3;
   localparam logic [1:0] EXT_RISE = 2'h1;
   localparam logic [1:0] EXT_FALL = 2'h2;
   localparam logic [1:0] EXT_BOTH = 2'h3;
   // Prescaler taps: bit k has a period of 2^(k+1) clocks
   localparam int PRESCALE_WIDTH = 10;
   localparam int TAP_DIV8 = 2;
   localparam int TAP_DIV64 = 5;
   localparam int TAP_DIV1024 = 9;
endpackage

// file: design/count_source.sv
// Purpose: Prescaler, clock source select and count pulse generation
// Assumes: ext_clk_in is asynchronous to clk
// Notes: Pulse comes from a falling edge of the selected level
`timescale 1ns/10ps
`default_nettype none
module count_source #(
   parameter int PRE_W = tmr_pkg::PRESCALE_WIDTH
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Control
   input wire logic [2:0] clock_sel,
   input wire logic ext_clk_in,
   // Result
   output logic count_pulse
);
   generate
      if (PRE_W < tmr_pkg::TAP_DIV1024 + 1) begin : g_bad_width
         $error("count_source: prescaler too narrow for the slowest tap");
      end
   endgenerate

   logic [PRE_W-1:0] prescale_r;
   logic ext_meta_r;
   logic ext_sync_r;
   logic ext_prev_r;
   logic level_prev_r;

   wire [1:0] sel_lo = clock_sel[1:0];
   wire int_level = (sel_lo == tmr_pkg::CKS_DIV8) ? prescale_r[tmr_pkg::TAP_DIV8] :
                    (sel_lo == tmr_pkg::CKS_DIV64) ? prescale_r[tmr_pkg::TAP_DIV64] :
                    (sel_lo == tmr_pkg::CKS_DIV1024) ? prescale_r[tmr_pkg::TAP_DIV1024] :
                    1'b0;
   // Rising mode counts a falling edge of the inverted input
   wire ext_level = (sel_lo == tmr_pkg::EXT_RISE) ? ~ext_sync_r :
                    (sel_lo == tmr_pkg::CKS_STOP) ? 1'b0 : ext_sync_r;
   wire sel_level = clock_sel[tmr_pkg::CTL_CKS_HI] ? ext_level : int_level;
   wire both_rise = clock_sel[tmr_pkg::CTL_CKS_HI] && (sel_lo == tmr_pkg::EXT_BOTH) &&
                    ext_sync_r && !ext_prev_r;

   // A reselection from high to low is itself a falling edge
   assign count_pulse = (level_prev_r && !sel_level) || both_rise;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prescale_r <= '0;
         ext_meta_r <= 1'b0;
         ext_sync_r <= 1'b0;
         ext_prev_r <= 1'b0;
         level_prev_r <= 1'b0;
      end else begin
         prescale_r <= prescale_r + 1'b1;
         ext_meta_r <= ext_clk_in;
         ext_sync_r <= ext_meta_r;
         ext_prev_r <= ext_sync_r;
         level_prev_r <= sel_level;
      end
   end
endmodule
`default_nettype wire

// file: design/match_unit.sv
// Purpose: One time-constant register with its compare-match detector
// Assumes: count_pulse marks the last cycle of the current count
// Notes: A write in the same cycle suppresses the match
`timescale 1ns/10ps
`default_nettype none
module match_unit (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Register write
   input wire logic wr_en,
   input wire logic [7:0] wdata,
   // Counter view
   input wire logic [7:0] count,
   input wire logic count_pulse,
   // Results
   output logic [7:0] constant,
   output logic match
);
   logic [7:0] const_r;

   // Match fires in the last state of the equal count
   assign match = count_pulse && (count == const_r) && !wr_en;
   assign constant = const_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         const_r <= tmr_pkg::CONST_RESET;
      end else if (wr_en) begin
         const_r <= wdata;
      end
   end
endmodule
`default_nettype wire

// file: design/timer_top.sv
// Purpose: One channel of an 8-bit compare-match timer with three requests
// Assumes: Single clock MCLK at 40 MHz; byte register port, read data next cycle
// Notes: External count and reset pins pass two flip-flops first
// Notes on behaviour
// - Three separate request lines: match A, match B, rollover.
// - Match A request high while its flag and enable are set.
// - Match B request high while its flag and enable are set.
// - Rollover request high while its flag and enable are set.
// - Clear select on match A returns counter to zero on match.
// - Output selection 0110: high on match A, low on match B.
// - Clear on A plus set/clear output gives autonomous periodic pulses.
// - Counter clear beats a simultaneous counter write.
// - Counter write beats a simultaneous increment, which is dropped.
// - Time constant write proceeds and suppresses its simultaneous match.
// - Simultaneous matches: toggle, then one, then zero, then no change.
// - Count pulse from falling edges; high to low reselect counts once.
// - High source to stopped counts once as a falling edge.
// - Reselecting while both sources are low adds no increment.
// - Internal/external source switch treated like any other edge.
// - Rollover flag set when counter goes from FF to 00.
// - Match flag set in the last state of the equal count.
// - Flags set by hardware; cleared by read-while-set then write zero.
// - Output select codes: 00 keep, 01 zero, 10 one, 11 toggle.
//
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/10ps
`default_nettype none
module timer_top (
   // Clock and reset
   input wire logic MCLK,
   input wire logic RSTN,
   // Register port
   input wire logic [2:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   // Pins
   input wire logic EXT_CLK,
   input wire logic EXT_RESET,
   output logic TIMER_OUT,
   output logic TIMER_OUT_EN,
   // Interrupt requests
   output logic MATCH_A_IRQ,
   output logic MATCH_B_IRQ,
   output logic OVERFLOW_IRQ
);
   logic [7:0] control_r;
   logic [3:0] out_sel_r;
   logic [2:0] flags_r;
   logic [2:0] flags_nxt;
   logic [2:0] armed_r;
   logic [2:0] armed_nxt;
   logic [7:0] count_r;
   logic [7:0] count_nxt;
   logic [7:0] rdata_r;
   logic out_r;
   logic out_nxt;
   logic xrst_meta_r;
   logic xrst_sync_r;
   logic xrst_prev_r;

   logic count_pulse;
   logic match_a;
   logic match_b;
   logic [7:0] const_a;
   logic [7:0] const_b;

   // Register decode
   wire wr_control = WR && (ADDR == tmr_pkg::OFF_CONTROL);
   wire wr_status = WR && (ADDR == tmr_pkg::OFF_STATUS);
   wire wr_const_a = WR && (ADDR == tmr_pkg::OFF_CONST_A);
   wire wr_const_b = WR && (ADDR == tmr_pkg::OFF_CONST_B);
   wire wr_counter = WR && (ADDR == tmr_pkg::OFF_COUNTER);
   wire rd_status = RD && (ADDR == tmr_pkg::OFF_STATUS);

   wire [1:0] clear_sel = control_r[tmr_pkg::CTL_CLR_HI:tmr_pkg::CTL_CLR_LO];
   wire [2:0] clock_sel = control_r[tmr_pkg::CTL_CKS_HI:0];
   wire [1:0] os_a = out_sel_r[tmr_pkg::ST_OS_A_HI:tmr_pkg::ST_OS_A_LO];
   wire [1:0] os_b = out_sel_r[tmr_pkg::ST_OS_B_HI:tmr_pkg::ST_OS_B_LO];
   wire [7:0] status_view = {flags_r, 1'b1, out_sel_r};

   count_source u_source (
      .clk(MCLK),
      .rst_n(RSTN),
      .clock_sel(clock_sel),
      .ext_clk_in(EXT_CLK),
      .count_pulse(count_pulse)
   );

   match_unit u_match_a (
      .clk(MCLK),
      .rst_n(RSTN),
      .wr_en(wr_const_a),
      .wdata(WDATA),
      .count(count_r),
      .count_pulse(count_pulse),
      .constant(const_a),
      .match(match_a)
   );

   match_unit u_match_b (
      .clk(MCLK),
      .rst_n(RSTN),
      .wr_en(wr_const_b),
      .wdata(WDATA),
      .count(count_r),
      .count_pulse(count_pulse),
      .constant(const_b),
      .match(match_b)
   );

   // Counter clear sources
   wire ext_clear = (clear_sel == tmr_pkg::CLR_EXT) && xrst_sync_r && !xrst_prev_r;
   wire cnt_clear = ((clear_sel == tmr_pkg::CLR_MATCH_A) && match_a) ||
                    ((clear_sel == tmr_pkg::CLR_MATCH_B) && match_b) || ext_clear;
   wire inc_eff = count_pulse && !cnt_clear && !wr_counter;
   wire rollover = inc_eff && (count_r == tmr_pkg::COUNT_MAX);

   // Clear, then write, then increment
   assign count_nxt = cnt_clear ? tmr_pkg::COUNTER_RESET :
                      wr_counter ? WDATA :
                      inc_eff ? 8'(count_r + 8'h01) : count_r;

   // Higher code wins when both matches act; code order is the precedence
   wire [1:0] act_a = match_a ? os_a : tmr_pkg::OUT_KEEP;
   wire [1:0] act_b = match_b ? os_b : tmr_pkg::OUT_KEEP;
   wire [1:0] act = (act_a > act_b) ? act_a : act_b;
   assign out_nxt = (act == tmr_pkg::OUT_TOGGLE) ? !out_r :
                    (act == tmr_pkg::OUT_ONE) ? 1'b1 :
                    (act == tmr_pkg::OUT_ZERO) ? 1'b0 : out_r;

   // Flags: a set in the same cycle as a clear wins
   wire [2:0] flag_set = {match_b, match_a, rollover};
   wire [2:0] wdata_flags = WDATA[tmr_pkg::ST_FLAG_HI:tmr_pkg::ST_FLAG_LO];
   wire [2:0] flag_clr = (wr_status ? (armed_r & ~wdata_flags) : 3'h0);
   assign flags_nxt = flag_set | (flags_r & ~flag_clr);
   assign armed_nxt = (rd_status ? (armed_r | flags_r) : armed_r) & flags_nxt;

   // Read mux; unmapped indices read zero
   wire [7:0] rd_mux = (ADDR == tmr_pkg::OFF_CONTROL) ? control_r :
                       (ADDR == tmr_pkg::OFF_STATUS) ? status_view :
                       (ADDR == tmr_pkg::OFF_CONST_A) ? const_a :
                       (ADDR == tmr_pkg::OFF_CONST_B) ? const_b :
                       (ADDR == tmr_pkg::OFF_COUNTER) ? count_r : 8'h00;

   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         control_r <= tmr_pkg::CONTROL_RESET;
         out_sel_r <= tmr_pkg::STATUS_RESET[3:0];
         flags_r <= tmr_pkg::STATUS_RESET[tmr_pkg::ST_FLAG_HI:tmr_pkg::ST_FLAG_LO];
         armed_r <= 3'h0;
         count_r <= tmr_pkg::COUNTER_RESET;
         out_r <= 1'b0;
         rdata_r <= 8'h00;
      end else begin
         if (wr_control) begin
            control_r <= WDATA;
         end
         if (wr_status) begin
            out_sel_r <= WDATA[3:0];
         end
         flags_r <= flags_nxt;
         armed_r <= armed_nxt;
         count_r <= count_nxt;
         out_r <= out_nxt;
         rdata_r <= RD ? rd_mux : 8'h00;
      end
   end

   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         xrst_meta_r <= 1'b0;
         xrst_sync_r <= 1'b0;
         xrst_prev_r <= 1'b0;
      end else begin
         xrst_meta_r <= EXT_RESET;
         xrst_sync_r <= xrst_meta_r;
         xrst_prev_r <= xrst_sync_r;
      end
   end

   assign RDATA = rdata_r;
   assign TIMER_OUT = out_r;
   assign TIMER_OUT_EN = |out_sel_r;
   // Three independent request lines
   assign MATCH_A_IRQ = flags_r[tmr_pkg::FLAG_A] && control_r[tmr_pkg::CTL_MATCH_A_IE];
   assign MATCH_B_IRQ = flags_r[tmr_pkg::FLAG_B] && control_r[tmr_pkg::CTL_MATCH_B_IE];
   assign OVERFLOW_IRQ = flags_r[tmr_pkg::FLAG_ROLL] && control_r[tmr_pkg::CTL_ROLL_IE];

   // Checks
   property p_match_a_irq;
      @(posedge MCLK) disable iff (!RSTN)
      (match_a && control_r[tmr_pkg::CTL_MATCH_A_IE] && !wr_control) |=> MATCH_A_IRQ;
   endproperty
   a_match_a_irq: assert property (p_match_a_irq) else $error("match A request missing");

   property p_match_b_irq;
      @(posedge MCLK) disable iff (!RSTN)
      (match_b && control_r[tmr_pkg::CTL_MATCH_B_IE] && !wr_control) |=> MATCH_B_IRQ;
   endproperty
   a_match_b_irq: assert property (p_match_b_irq) else $error("match B request missing");

   property p_rollover;
      @(posedge MCLK) disable iff (!RSTN)
      rollover |=> (count_r == 8'h00) && flags_r[tmr_pkg::FLAG_ROLL] &&
                   (OVERFLOW_IRQ == control_r[tmr_pkg::CTL_ROLL_IE]);
   endproperty
   a_rollover: assert property (p_rollover) else $error("rollover not flagged");

   property p_clear_on_a;
      @(posedge MCLK) disable iff (!RSTN)
      (match_a && clear_sel == tmr_pkg::CLR_MATCH_A) |=> (count_r == 8'h00);
   endproperty
   a_clear_on_a: assert property (p_clear_on_a) else $error("counter not cleared on A");

   property p_clear_beats_write;
      @(posedge MCLK) disable iff (!RSTN)
      (cnt_clear && wr_counter) |=> (count_r == 8'h00);
   endproperty
   a_clear_beats_write: assert property (p_clear_beats_write) else $error("write beat clear");

   property p_write_beats_inc;
      @(posedge MCLK) disable iff (!RSTN)
      (wr_counter && count_pulse && !cnt_clear) |=> (count_r == $past(WDATA));
   endproperty
   a_write_beats_inc: assert property (p_write_beats_inc) else $error("increment beat write");

   property p_const_write_mutes;
      @(posedge MCLK) disable iff (!RSTN)
      (WR && ADDR == tmr_pkg::OFF_CONST_A) |-> !match_a ##1 (const_a == $past(WDATA));
   endproperty
   a_const_write_mutes: assert property (p_const_write_mutes) else $error("match not muted");

   property p_toggle_wins;
      @(posedge MCLK) disable iff (!RSTN)
      (match_a && match_b && (os_a == tmr_pkg::OUT_TOGGLE || os_b == tmr_pkg::OUT_TOGGLE))
         |=> (TIMER_OUT != $past(TIMER_OUT));
   endproperty
   a_toggle_wins: assert property (p_toggle_wins) else $error("toggle lost priority");

   property p_pulse_mode;
      @(posedge MCLK) disable iff (!RSTN)
      (match_b && !match_a && os_b == tmr_pkg::OUT_ZERO) |=> !TIMER_OUT;
   endproperty
   a_pulse_mode: assert property (p_pulse_mode) else $error("output not driven low");

   property p_write_one_keeps;
      @(posedge MCLK) disable iff (!RSTN)
      (wr_status && WDATA[tmr_pkg::ST_FLAG_HI] && !flags_r[tmr_pkg::FLAG_B] && !match_b)
         |=> !flags_r[tmr_pkg::FLAG_B];
   endproperty
   a_write_one_keeps: assert property (p_write_one_keeps) else $error("software set a flag");

   c_pulse_cycle: cover property (@(posedge MCLK) disable iff (!RSTN)
      (match_a && out_sel_r == 4'h6) ##[1:1000] (match_b && !TIMER_OUT_EN == 1'b0));
   c_overflow_irq: cover property (@(posedge MCLK) disable iff (!RSTN) $rose(OVERFLOW_IRQ));
   c_clear_vs_write: cover property (@(posedge MCLK) disable iff (!RSTN) cnt_clear && wr_counter);
endmodule
`default_nettype wire

// file: verification/irq_ctrl_model.sv
// Purpose: Interrupt controller stand-in that ranks the three request lines
// Assumes: Request lines are levels held by the timer
// Notes: Winner code 3 match A, 2 match B, 1 rollover, 0 none
`timescale 1ns/10ps
`default_nettype none
module irq_ctrl_model (
   // Requests
   input wire logic req_a,
   input wire logic req_b,
   input wire logic req_roll,
   // Highest pending request
   output logic [1:0] winner
);
   // Fixed ranking: match A over match B over rollover
   assign winner = req_a ? 2'h3 :
      req_b ? 2'h2 :
      req_roll ? 2'h1 : 2'h0;
endmodule
`default_nettype wire

// file: verification/eight_bit_timer_irq_contention_tb.sv
// Purpose: Self-checking bench for one compare-match timer channel
// Assumes: MCLK 40 MHz, register port with read data one cycle after the strobe
// Notes: External count and reset pins move only while no source switch is made
`timescale 1ns/10ps
`default_nettype none
module eight_bit_timer_irq_contention_tb;
   logic clk;
   logic rst_n;
   logic [2:0] addr;
   logic [7:0] wdata;
   logic wr;
   logic rd;
   logic [7:0] rdata;
   logic tout;
   logic tout_en;
   logic irq_a;
   logic irq_b;
   logic irq_roll;
   logic [1:0] winner;
   logic ext_clk;
   logic ext_rst;
   logic [7:0] v;
   int n_mismatch;
   int n_checks;
   int hi;
   int lo;
   localparam logic [7:0] RST_VAL [6] = '{8'h00, 8'h10, 8'hFF, 8'hFF, 8'h00, 8'h00};
   // Output select bytes {os_b, os_a} and the level expected after a joint match
   localparam logic [7:0] PRI_OS [5] = '{8'h08, 8'h09, 8'h0E, 8'h03, 8'h04};
   localparam logic PRI_EXP [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};

   // External pins are quiet whenever the clock select is rewritten
   timer_top DUT (
      .MCLK(clk), .RSTN(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
      .RDATA(rdata), .EXT_CLK(ext_clk), .EXT_RESET(ext_rst), .TIMER_OUT(tout),
      .TIMER_OUT_EN(tout_en), .MATCH_A_IRQ(irq_a), .MATCH_B_IRQ(irq_b),
      .OVERFLOW_IRQ(irq_roll)
   );
   irq_ctrl_model ICM (.req_a(irq_a), .req_b(irq_b), .req_roll(irq_roll), .winner(winner));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         $display("ERROR %s expected %h seen %h", what, exp, got);
         n_mismatch++;
      end
   endtask

   task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rd_chk(input string what, input logic [2:0] a, input logic [7:0] exp);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(what, exp, rdata);
      @(posedge clk);
   endtask

   // Waits for the output (sel 0) or the rollover request (sel 1) to reach want
   task automatic wait_for(input int sel, input logic want, output int n);
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (((sel == 0) ? tout : irq_roll) !== want && n < 600);
      if (n >= 600) begin
         $display("ERROR wait_for expected %h seen timeout", want);
         n_mismatch++;
      end
   endtask

   task automatic do_reset();
      rst_n <= 1'b0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      stop_test();
   end

   initial begin
      n_mismatch = 0;
      n_checks = 0;
      rst_n = 1'b0;
      addr = 3'h0;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      ext_clk = 1'b0;
      ext_rst = 1'b0;
      do_reset();
      for (int i = 0; i < 6; i++) begin
         rd_chk("reset_value", 3'(i), RST_VAL[i]);
      end
      chk("reset_out", 8'h00, {5'h00, tout, tout_en, irq_a | irq_b | irq_roll});
      // Periodic pulse: clear on A, high on A, low on B, /8 count
      wr_reg(tmr_pkg::OFF_CONST_A, 8'h04);
      wr_reg(tmr_pkg::OFF_CONST_B, 8'h01);
      wr_reg(tmr_pkg::OFF_STATUS, 8'h06);
      wr_reg(tmr_pkg::OFF_CONTROL, 8'hC9);
      wait_for(0, 1'b1, hi);
      wait_for(0, 1'b0, hi);
      wait_for(0, 1'b1, lo);
      chk("high_width", 8'h10, 8'(hi));
      chk("low_width", 8'h18, 8'(lo));
      chk("out_enable", 8'h01, {7'h00, tout_en});
      chk("irq_a_b", 8'h03, {6'h00, irq_a, irq_b});
      chk("winner", 8'h03, {6'h00, winner});
      wr_reg(tmr_pkg::OFF_CONTROL, 8'hC0);
      // Flag clearing needs a read while set, and ones never set a flag
      wr_reg(tmr_pkg::OFF_STATUS, 8'h06);
      rd_chk("status_unread", tmr_pkg::OFF_STATUS, 8'hD6);
      wr_reg(tmr_pkg::OFF_STATUS, 8'h96);
      rd_chk("status_clr_a", tmr_pkg::OFF_STATUS, 8'h96);
      chk("irq_after_a", 8'h01, {6'h00, irq_a, irq_b});
      chk("winner_b", 8'h02, {6'h00, winner});
      wr_reg(tmr_pkg::OFF_STATUS, 8'h16);
      rd_chk("status_clr_b", tmr_pkg::OFF_STATUS, 8'h16);
      chk("irq_after_b", 8'h00, {6'h00, irq_a, irq_b});
      wr_reg(tmr_pkg::OFF_STATUS, 8'hF6);
      rd_chk("status_set_try", tmr_pkg::OFF_STATUS, 8'h16);
      // Rollover from FE through FF to 00
      wr_reg(tmr_pkg::OFF_CONST_A, 8'h80);
      wr_reg(tmr_pkg::OFF_CONST_B, 8'h80);
      wr_reg(tmr_pkg::OFF_CONTROL, 8'h20);
      wr_reg(tmr_pkg::OFF_COUNTER, 8'hFE);
      wr_reg(tmr_pkg::OFF_CONTROL, 8'h21);
      wait_for(1, 1'b1, hi);
      wr_reg(tmr_pkg::OFF_CONTROL, 8'h20);
      rd_chk("status_roll", tmr_pkg::OFF_STATUS, 8'h36);
      chk("winner_roll", 8'h01, {6'h00, winner});
      wr_reg(tmr_pkg::OFF_CONTROL, 8'h00);
      chk("irq_roll_off", 8'h00, {7'h00, irq_roll});
      // Held counter writes across count pulses at several phases
      wr_reg(tmr_pkg::OFF_CONTROL, 8'h01);
      for (int i = 0; i < 8; i++) begin
         repeat (i) @(posedge clk);
         addr <= tmr_pkg::OFF_COUNTER;
         wdata <= 8'(8'h40 + i);
         wr <= 1'b1;
         repeat (9) @(posedge clk);
         wr <= 1'b0;
         rd_chk("counter_write", tmr_pkg::OFF_COUNTER, 8'(8'h40 + i));
      end
      // Joint matches from a known output level after reset
      do_reset();
      wr_reg(tmr_pkg::OFF_CONST_A, 8'h02);
      wr_reg(tmr_pkg::OFF_CONST_B, 8'h02);
      for (int i = 0; i < 5; i++) begin
         wr_reg(tmr_pkg::OFF_COUNTER, 8'h02);
         wr_reg(tmr_pkg::OFF_STATUS, PRI_OS[i]);
         wr_reg(tmr_pkg::OFF_CONTROL, 8'h01);
         // One /8 pulse leaves the count 2 within this span, the next one cannot match
         repeat (12) @(posedge clk);
         wr_reg(tmr_pkg::OFF_CONTROL, 8'h00);
         chk("joint_out", {7'h00, PRI_EXP[i]}, {7'h00, tout});
      end
      // Toggle on A marks the /8 phase: the match edge is 1 edge after a prescaler fall
      wr_reg(tmr_pkg::OFF_STATUS, 8'h03);
      wr_reg(tmr_pkg::OFF_COUNTER, 8'h02);
      wr_reg(tmr_pkg::OFF_CONTROL, 8'h01);
      wait_for(0, 1'b1, hi);
      // Stop while the /8 level is high: one extra count
      repeat (3) @(posedge clk);
      wr_reg(tmr_pkg::OFF_CONTROL, 8'h00);
      rd_chk("counter_stop_high", tmr_pkg::OFF_COUNTER, 8'h04);
      // Stop to /8 and back while the level is low: no count
      wr_reg(tmr_pkg::OFF_CONTROL, 8'h01);
      wr_reg(tmr_pkg::OFF_CONTROL, 8'h00);
      rd_chk("counter_stop_low", tmr_pkg::OFF_COUNTER, 8'h04);
      // External rising count, then a switch from the high external level to stop
      wr_reg(tmr_pkg::OFF_COUNTER, 8'h00);
      wr_reg(tmr_pkg::OFF_CONTROL, 8'h05);
      for (int i = 0; i < 3; i++) begin
         ext_clk <= 1'b1;
         repeat (4) @(posedge clk);
         ext_clk <= 1'b0;
         repeat (4) @(posedge clk);
      end
      rd_chk("counter_ext", tmr_pkg::OFF_COUNTER, 8'h03);
      wr_reg(tmr_pkg::OFF_CONTROL, 8'h00);
      rd_chk("counter_ext_switch", tmr_pkg::OFF_COUNTER, 8'h04);
      // External clear lands in the same cycle as a counter write
      wr_reg(tmr_pkg::OFF_CONTROL, 8'h18);
      ext_rst <= 1'b1;
      repeat (2) @(posedge clk);
      wr_reg(tmr_pkg::OFF_COUNTER, 8'h55);
      ext_rst <= 1'b0;
      rd_chk("counter_clear_wins", tmr_pkg::OFF_COUNTER, 8'h00);
      stop_test();
   end
endmodule
`default_nettype wire
